// ==== rtl/uvps_pkg.sv ====
// Constants, register map and state encoding of the three-stage undervoltage protection block.
// Assumes a 20 MHz system clock and voltage magnitudes given in per mille of nominal voltage.
`default_nettype none

package uvps_pkg;

    // ------------------------------------------------------------
    // Structure and timing
    // ------------------------------------------------------------
    localparam int NSTAGE = 3;
    localparam int NGROUP = 4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_MS = 10;
    localparam int TICK_CYCLES_DFLT = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Setting ranges and scaling
    // ------------------------------------------------------------
    localparam int PM_FULL = 1000;
    localparam int PCT_TO_PM = 10;
    localparam int START_MIN_PCT = 20;
    localparam int START_MAX_PCT = 120;
    localparam int BLOCK_MAX_PCT = 80;
    localparam int HYST_MIN_PM = 1;
    localparam int HYST_MAX_PM = 200;
    localparam int BLK_REL_RATIO_PCT = 103;
    localparam int BLK_MARGIN_DV = 5;
    localparam int UN_SEC_DV_DFLT = 1000;
    // Delays are counted in 10 ms ticks.
    localparam logic [15:0] DELAY_MAX_TICKS = 16'h7530;
    localparam logic [15:0] OP_MIN_TICKS [NSTAGE] = '{16'h0008, 16'h0006, 16'h0004};
    localparam logic [15:0] STEP_MASK [NSTAGE] = '{16'hfffe, 16'hfffe, 16'hffff};
    localparam logic [15:0] REL_MIN_TICKS = 16'h0006;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_A_OFF = 12'h000;
    localparam logic [11:0] CFG_B_OFF = 12'h004;
    localparam logic [11:0] STAGE_STRIDE = 12'h008;
    localparam logic [11:0] GROUP_STRIDE = 12'h040;
    localparam logic [11:0] CTRL_OFF = 12'h100;
    localparam logic [11:0] STATUS_OFF = 12'h104;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h108;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h10c;
    localparam logic [11:0] VMEAS_OFF = 12'h110;

    localparam int START_POS = 0;
    localparam int BLOCK_POS = 8;
    localparam int HYST_POS = 16;
    localparam int OP_POS = 0;
    localparam int REL_POS = 16;
    localparam int GRP_POS = 0;
    localparam int ACCEPT_POS = 4;
    localparam int ST_START_POS = 0;
    localparam int ST_TRIP_POS = 3;
    localparam int ST_SBLK_POS = 6;

    localparam logic [6:0] START_RST = 7'h46;
    localparam logic [6:0] BLOCK_RST = 7'h0a;
    localparam logic [7:0] HYST_RST = 8'h1e;
    localparam logic [15:0] OP_RST = 16'h0032;
    localparam logic [15:0] REL_RST = 16'h0006;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_0073;

    // ------------------------------------------------------------
    // Stage state: bit 0 is the start flag, bit 1 the trip flag
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STARTED = 2'b01,
        ST_TRIPPED = 2'b11,
        ST_RELEASING = 2'b10
    } uvps_state_e;

endpackage : uvps_pkg

`default_nettype wire

// ==== rtl/uvps_top.sv ====
// Three-stage undervoltage protection block with an AHB-Lite register slave.
// Assumes line-to-line magnitudes in per mille of nominal, synchronous to clk, and an external block matrix.
//
// What this block does
// R01 - Start a stage when the smallest line-to-line voltage drops below its threshold.
// R02 - Trip a started stage after the undervoltage persists beyond its operate delay.
// R03 - An external block input per stage suppresses start and trip.
// R04 - Self-block the stage while the largest line-to-line voltage is below its limit.
// R05 - A block limit of zero disables self-blocking.
// R06 - Software should keep the block limit at 15% or more for delays below 0.08 s.
// R07 - Three independently configured definite-time stages.
// R08 - Settings come from one of four selectable setting groups.
// R09 - Start threshold settable 20 to 120 percent in steps of one percent.
// R10 - Stages one and two delay minima 0.08 and 0.06 s, to 300 s, step 0.02 s.
// R11 - Stage three delay 0.04 to 300 s in 0.01 s steps.
// R12 - Release hysteresis ratio 1.001 to 1.200 in 0.1 percent steps.
// R13 - Self-block limit settable 0 to 80 percent of nominal.
// R14 - Stage one release delay 0.06 to 300 s in 0.02 s steps.
// R15 - Self-block releases above limit plus the larger of 0.5 V or 3 percent.
// R16 - Zero operate delay only when accept-zero-delay is set, else the minimum applies.
// R17 - Start and timer clear when voltage exceeds threshold times hysteresis, or on block.
// R18 - Trip holds until start releases, then clears after any release delay.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`default_nettype none

module uvps_top
    import uvps_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
    parameter int UN_SEC_DV = UN_SEC_DV_DFLT,
    parameter int VW = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [VW-1:0] v12,
    input wire logic [VW-1:0] v23,
    input wire logic [VW-1:0] v31,
    input wire logic [NSTAGE-1:0] ext_block,
    output logic [NSTAGE-1:0] start_flag,
    output logic [NSTAGE-1:0] trip_flag,
    output logic irq
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int MARGIN_PM = (BLK_MARGIN_DV * PM_FULL + UN_SEC_DV - 1) / UN_SEC_DV;
    localparam int NSLOT = NSTAGE * NGROUP;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Returns {hit, slot index} for an address in the settings area.
    function automatic logic [4:0] cfg_slot(input logic [11:0] a);
        logic hit;
        hit = (a[11:8] == 4'h0) && (a[5] == 1'b0) && (a[4:3] != 2'h3) && (a[1:0] == 2'h0);
        return {hit, 4'(a[7:6] * 2'd3) + {2'h0, a[4:3]}};
    endfunction : cfg_slot

    function automatic logic [31:0] clamp_a(input logic [31:0] w);
        logic [6:0] st;
        logic [6:0] bl;
        logic [7:0] hy;
        st = w[START_POS +: 7];
        bl = w[BLOCK_POS +: 7];
        hy = w[HYST_POS +: 8];
        if (st < 7'(START_MIN_PCT)) st = 7'(START_MIN_PCT); // see R09
        if (st > 7'(START_MAX_PCT)) st = 7'(START_MAX_PCT); // see R09
        if (bl > 7'(BLOCK_MAX_PCT)) bl = 7'(BLOCK_MAX_PCT); // see R13
        if (hy < 8'(HYST_MIN_PM)) hy = 8'(HYST_MIN_PM); // see R12
        if (hy > 8'(HYST_MAX_PM)) hy = 8'(HYST_MAX_PM); // see R12
        return {8'h00, hy, 1'b0, bl, 1'b0, st};
    endfunction : clamp_a

    // Zero is kept so that the accept-zero-delay setting can decide at use.
    function automatic logic [31:0] clamp_b(input logic [31:0] w, input logic [1:0] s);
        logic [15:0] op;
        logic [15:0] rel;
        op = w[OP_POS +: 16] & STEP_MASK[s]; // see R10 R11
        rel = w[REL_POS +: 16] & STEP_MASK[0]; // see R14
        if (op > DELAY_MAX_TICKS) op = DELAY_MAX_TICKS & STEP_MASK[s];
        if (op != 16'h0000 && op < OP_MIN_TICKS[s]) op = OP_MIN_TICKS[s]; // see R10 R11
        if (rel > DELAY_MAX_TICKS) rel = DELAY_MAX_TICKS & STEP_MASK[0];
        if (rel < REL_MIN_TICKS) rel = REL_MIN_TICKS; // see R14
        if (s != 2'h0) rel = 16'h0000;
        return {rel, op};
    endfunction : clamp_b

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [31:0] cfg_a_mem [NSLOT];
    logic [31:0] cfg_b_mem [NSLOT];
    logic [31:0] ctrl_reg;
    logic [5:0] irq_stat_reg;
    logic [5:0] irq_mask_reg;
    logic [11:0] addr_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rdata_next;
    logic [TW-1:0] tick_cnt_reg;
    logic tick;
    uvps_state_e state_reg [NSTAGE];
    uvps_state_e state_next [NSTAGE];
    logic [15:0] cnt_reg [NSTAGE];
    logic [15:0] cnt_next [NSTAGE];
    logic [NSTAGE-1:0] sblk_reg;
    logic [NSTAGE-1:0] sblk_next;
    logic [NSTAGE-1:0] blocked;
    logic [NSTAGE-1:0] under_set;
    logic [NSTAGE-1:0] under_hold;
    logic [15:0] op_eff [NSTAGE];
    logic [15:0] rel_eff [NSTAGE];
    logic [31:0] act_a [NSTAGE];
    logic [31:0] act_b [NSTAGE];
    logic [VW-1:0] vmin;
    logic [VW-1:0] vmax;
    logic [31:0] vmin32;
    logic [31:0] vmax32;
    logic [31:0] st32;
    logic [31:0] bl32;
    logic [5:0] ev;
    logic acc;
    logic [4:0] wslot;
    logic [4:0] rslot;

    // ------------------------------------------------------------
    // Tick divider: one pulse every 10 ms
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + TW'(1);
        end
    end
    assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

    // ------------------------------------------------------------
    // Stage evaluation
    // ------------------------------------------------------------
    always_comb begin
        vmin = v12;
        if (v23 < vmin) vmin = v23;
        if (v31 < vmin) vmin = v31;
        vmax = v12;
        if (v23 > vmax) vmax = v23;
        if (v31 > vmax) vmax = v31;
        vmin32 = 32'(vmin);
        vmax32 = 32'(vmax);
        st32 = '0;
        bl32 = '0;
        ev = '0;
        for (int s = 0; s < NSTAGE; s++) begin // see R07
            act_a[s] = cfg_a_mem[int'(ctrl_reg[GRP_POS +: 2]) * NSTAGE + s]; // see R08
            act_b[s] = cfg_b_mem[int'(ctrl_reg[GRP_POS +: 2]) * NSTAGE + s]; // see R08
            st32 = 32'(act_a[s][START_POS +: 7]);
            bl32 = 32'(act_a[s][BLOCK_POS +: 7]);
            under_set[s] = vmin32 < st32 * 32'(PCT_TO_PM); // see R01
            under_hold[s] = vmin32 * 32'd100 <= st32 * (32'(PM_FULL) + 32'(act_a[s][HYST_POS +: 8])); // see R12 R17
            sblk_next[s] = sblk_reg[s];
            if (bl32 == 32'h0) begin
                sblk_next[s] = 1'b0; // see R05
            end else if (vmax32 < bl32 * 32'(PCT_TO_PM)) begin
                sblk_next[s] = 1'b1; // see R04
            end else if (vmax32 * 32'd100 > bl32 * 32'(PCT_TO_PM * BLK_REL_RATIO_PCT)
                         && vmax32 > bl32 * 32'(PCT_TO_PM) + 32'(MARGIN_PM)) begin
                sblk_next[s] = 1'b0; // see R15
            end
            blocked[s] = ext_block[s] | sblk_reg[s]; // see R03 R04
            op_eff[s] = act_b[s][OP_POS +: 16];
            if (op_eff[s] == 16'h0000 && !ctrl_reg[ACCEPT_POS + s]) op_eff[s] = OP_MIN_TICKS[s]; // see R16
            rel_eff[s] = act_b[s][REL_POS +: 16];
            state_next[s] = state_reg[s];
            cnt_next[s] = cnt_reg[s];
            if (blocked[s]) begin
                state_next[s] = ST_IDLE; // see R03 R17
                cnt_next[s] = '0;
            end else begin
                unique case (state_reg[s])
                    ST_IDLE: begin
                        if (under_set[s]) begin
                            state_next[s] = ST_STARTED; // see R01
                            cnt_next[s] = '0;
                        end
                    end
                    ST_STARTED: begin
                        if (!under_hold[s]) begin
                            state_next[s] = ST_IDLE; // see R17
                            cnt_next[s] = '0;
                        end else if (cnt_reg[s] >= op_eff[s]) begin
                            state_next[s] = ST_TRIPPED; // see R02
                            cnt_next[s] = '0;
                        end else if (tick) begin
                            cnt_next[s] = cnt_reg[s] + 16'h0001;
                        end
                    end
                    ST_TRIPPED: begin
                        if (!under_hold[s]) begin
                            state_next[s] = (rel_eff[s] != 16'h0000) ? ST_RELEASING : ST_IDLE; // see R18
                            cnt_next[s] = '0;
                        end
                    end
                    ST_RELEASING: begin
                        if (under_set[s]) begin
                            state_next[s] = ST_TRIPPED; // see R18
                            cnt_next[s] = '0;
                        end else if (cnt_reg[s] >= rel_eff[s]) begin
                            state_next[s] = ST_IDLE; // see R14 R18
                            cnt_next[s] = '0;
                        end else if (tick) begin
                            cnt_next[s] = cnt_reg[s] + 16'h0001;
                        end
                    end
                endcase
            end
            ev[s] = state_next[s][0] & ~state_reg[s][0];
            ev[NSTAGE + s] = state_next[s][1] & ~state_reg[s][1];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int s = 0; s < NSTAGE; s++) begin
                state_reg[s] <= ST_IDLE;
                cnt_reg[s] <= '0;
            end
            sblk_reg <= '0;
        end else begin
            for (int s = 0; s < NSTAGE; s++) begin
                state_reg[s] <= state_next[s];
                cnt_reg[s] <= cnt_next[s];
            end
            sblk_reg <= sblk_next;
        end
    end

    always_comb begin
        for (int s = 0; s < NSTAGE; s++) begin
            start_flag[s] = state_reg[s][0];
            trip_flag[s] = state_reg[s][1];
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave: writes take no wait state, reads take one
    // ------------------------------------------------------------
    assign acc = hsel & htrans[1] & hready;
    assign hreadyout = ~rd_pend_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign wslot = cfg_slot(addr_reg);
    assign rslot = cfg_slot(addr_reg);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= '0;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= acc & hwrite;
            rd_pend_reg <= acc & ~hwrite;
            if (acc) addr_reg <= haddr[11:0];
        end
    end

    always_comb begin
        rdata_next = '0;
        if (rslot[4]) begin
            rdata_next = addr_reg[2] ? cfg_b_mem[rslot[3:0]] : cfg_a_mem[rslot[3:0]];
        end else begin
            unique case (addr_reg)
                CTRL_OFF: rdata_next = ctrl_reg;
                STATUS_OFF: rdata_next = 32'({sblk_reg, trip_flag, start_flag});
                IRQ_STAT_OFF: rdata_next = 32'(irq_stat_reg);
                IRQ_MASK_OFF: rdata_next = 32'(irq_mask_reg);
                VMEAS_OFF: rdata_next = {16'(vmax), 16'(vmin)};
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata_reg <= '0;
        end else if (rd_pend_reg) begin
            hrdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NSLOT; i++) begin
                cfg_a_mem[i] <= {8'h00, HYST_RST, 1'b0, BLOCK_RST, 1'b0, START_RST};
                cfg_b_mem[i] <= (i % NSTAGE == 0) ? {REL_RST, OP_RST} : {16'h0000, OP_RST};
            end
        end else if (wr_pend_reg && wslot[4]) begin
            if (addr_reg[2]) begin
                cfg_b_mem[wslot[3:0]] <= clamp_b(hwdata, addr_reg[4:3]);
            end else begin
                cfg_a_mem[wslot[3:0]] <= clamp_a(hwdata);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= '0;
            irq_mask_reg <= '0;
        end else if (wr_pend_reg) begin
            if (addr_reg == CTRL_OFF) ctrl_reg <= hwdata & CTRL_WMASK;
            if (addr_reg == IRQ_MASK_OFF) irq_mask_reg <= hwdata[5:0];
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_pend_reg && addr_reg == IRQ_STAT_OFF) ? hwdata[5:0] : 6'h00)) | ev;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    for (genvar g = 0; g < NSTAGE; g++) begin : g_chk
        ext_block_a: assert property (ext_block[g] |=> !start_flag[g] && !trip_flag[g]) // see R03
            else $error("stage active in the cycle after its block input");
        self_block_a: assert property ((act_a[g][BLOCK_POS +: 7] != 7'h00) && $stable(act_a[g])
                && vmax32 < 32'(act_a[g][BLOCK_POS +: 7]) * 32'(PCT_TO_PM) |=> sblk_reg[g] ##1 !start_flag[g]) // see R04
            else $error("low voltage did not self-block the stage");
        zero_limit_a: assert property (act_a[g][BLOCK_POS +: 7] == 7'h00 |=> !sblk_reg[g]) // see R05
            else $error("self-block set with a zero block limit");
        start_set_a: assert property (state_reg[g] == ST_IDLE && !blocked[g] && under_set[g] |=> start_flag[g]) // see R01
            else $error("stage failed to start on undervoltage");
        trip_cause_a: assert property ($rose(trip_flag[g]) |-> $past(start_flag[g]) && $past(cnt_reg[g]) >= $past(op_eff[g])) // see R02
            else $error("trip without expired operate delay");
        hyst_release_a: assert property (state_reg[g] == ST_STARTED && !blocked[g] && !under_hold[g] |=> !start_flag[g]
                && cnt_reg[g] == 16'h0000) // see R17
            else $error("start held above the release level");
        zero_delay_a: assert property (act_b[g][OP_POS +: 16] == 16'h0000 && !ctrl_reg[ACCEPT_POS + g]
                |-> op_eff[g] == OP_MIN_TICKS[g]) // see R16
            else $error("zero delay used without acceptance");
        start_range_a: assert property (act_a[g][START_POS +: 7] >= 7'(START_MIN_PCT)
                && act_a[g][START_POS +: 7] <= 7'(START_MAX_PCT)) // see R09
            else $error("start threshold outside its range");
    end

    trip_hold_a: assert property (state_reg[0] == ST_TRIPPED && !blocked[0] && !under_hold[0]
            |=> trip_flag[0] && !start_flag[0]) // see R14 R18
        else $error("stage one trip dropped without its release delay");

    read_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly two cycles");

endmodule : uvps_top

`default_nettype wire

// ==== verification/uvps_bench.sv ====
// Self-checking bench of the undervoltage block, registers reached over AHB-Lite.
// Assumes the front end model drives the voltages and the block lines.
`default_nettype none

module uvps_bench;
    import uvps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 4;
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irq, rdy_s, irq_s;
    logic [15:0] v12, v23, v31;
    logic [2:0] ext_block, start_flag, trip_flag, start_s, trip_s;
    logic [7:0] trips_seen;
    int mismatches = 0, comparisons = 0;

    always #25 clk = ~clk;

    // Outputs are copied at the falling edge, so checks at a rising edge see settled values.
    always @(negedge clk) {rdy_s, irq_s, start_s, trip_s} <= {hreadyout, irq, start_flag, trip_flag};

    uvps_top #(.TICK_CYCLES(T)) dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .v12(v12), .v23(v23), .v31(v31), .ext_block(ext_block),
        .start_flag(start_flag), .trip_flag(trip_flag), .irq(irq));
    uvps_meas_model fe (.clk(clk), .resetn(resetn), .trip_flag(trip_flag), .v12(v12), .v23(v23),
        .v31(v31), .ext_block(ext_block), .trips_seen(trips_seen));

    // ------------------------------------------------------------
    // Bus and checking helpers
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask : check

    task automatic wait_ready;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rdy_s === 1'b1) return;
        end
        mismatches++;
        wrap_up();
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, q, exp);
        check("hresp", hresp, 1'b0);
    endtask : rdc

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdc("cfg_a g0s0", CFG_A_OFF, 32'h001e0a46);
        rdc("cfg_b g3s0", 12'h0c4, 32'h00060032);
        rdc("cfg_b g0s2", 12'h014, 32'h00000032);
        wr(STATUS_OFF, 32'hffffffff);
        rdc("status", STATUS_OFF, 32'h0);
        wr(12'h200, 32'hffffffff);
        rdc("unmapped", 12'h200, 32'h0);
        check("flags", {start_s, trip_s, irq_s}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_clamp;
        wr(12'h008, 32'h00005a05);
        rdc("clamp cfg_a", 12'h008, 32'h00015014);
        wr(12'h004, 32'h00030003);
        rdc("clamp s1", 12'h004, 32'h00060008);
        wr(12'h00c, 32'h00000007);
        rdc("clamp s2", 12'h00c, 32'h00000006);
        wr(12'h014, 32'hffff7531);
        rdc("clamp s3", 12'h014, 32'h00007530);
        $display("test clamp done");
    endtask : t_clamp

    task automatic t_timing;
        int op[3] = '{8, 6, 4};
        int t[3] = '{0, 0, 0};
        int n;
        for (int s = 0; s < 3; s++) wr(12'(8 * s), 32'h001e0f46);
        wr(12'h014, 32'h00000004);
        fe.set_v(16'd690, 16'd1000, 16'd1000);
        settle(3);
        check("start", start_s, 3'b111);
        for (n = 0; n < 200 && trip_s !== 3'b111; n++) begin
            @(posedge clk);
            for (int s = 0; s < 3; s++) if (trip_s[s] === 1'b1 && t[s] == 0) t[s] = n + 1;
        end
        for (int s = 0; s < 3; s++) check("trip time", t[s] >= (op[s] - 1) * T && t[s] <= (op[s] + 2) * T + 4, 1);
        if (n >= 200) wrap_up();
        fe.set_v(16'd721, 16'd1000, 16'd1000);
        settle(4);
        check("hyst hold", start_s, 3'b111);
        fe.set_v(16'd722, 16'd1000, 16'd1000);
        settle(3);
        check("hyst rel", {start_s, trip_s}, 6'b000001);
        for (n = 0; n < 100 && trip_s[0] !== 1'b0; n++) @(posedge clk);
        check("release", n >= 5 * T && n <= 8 * T + 4, 1);
        if (n >= 100) wrap_up();
        check("trips seen", trips_seen, 32'd3);
        $display("test timing done");
    endtask : t_timing

    task automatic t_blocks;
        fe.set_blk(3'b001);
        fe.set_v(16'd500, 16'd1000, 16'd1000);
        settle(3);
        check("ext block", start_s, 3'b110);
        fe.set_blk(3'b010);
        settle(3);
        check("ext block 2", start_s, 3'b101);
        fe.set_blk(3'b000);
        fe.set_v(16'd140, 16'd140, 16'd140);
        settle(4);
        check("self block", start_s, 3'b000);
        rdc("sblk status", STATUS_OFF, 32'h000001c0);
        rdc("vmeas", VMEAS_OFF, 32'h008c008c);
        fe.set_v(16'd155, 16'd155, 16'd155);
        settle(4);
        check("sblk margin", start_s, 3'b000);
        fe.set_v(16'd156, 16'd156, 16'd156);
        settle(4);
        check("sblk rel", start_s, 3'b111);
        wr(12'h000, 32'h001e0046);
        fe.set_v(16'd0, 16'd0, 16'd0);
        settle(4);
        check("limit zero", start_s, 3'b001);
        fe.set_v(16'd1000, 16'd1000, 16'd1000);
        settle(4);
        $display("test blocks done");
    endtask : t_blocks

    task automatic t_group;
        wr(12'h040, 32'h001e0f32);
        wr(12'h054, 32'h00000000);
        wr(CTRL_OFF, 32'h00000041);
        fe.set_v(16'd600, 16'd1000, 16'd1000);
        settle(4);
        check("group", start_s, 3'b110);
        check("zero delay", trip_s, 3'b100);
        fe.set_v(16'd1000, 16'd1000, 16'd1000);
        settle(3);
        wr(CTRL_OFF, 32'h00000001);
        fe.set_v(16'd600, 16'd1000, 16'd1000);
        settle(4);
        check("zero refused", trip_s, 3'b000);
        fe.set_v(16'd1000, 16'd1000, 16'd1000);
        wr(CTRL_OFF, 32'h00000000);
        settle(3);
        $display("test group done");
    endtask : t_group

    task automatic t_irq;
        wr(IRQ_MASK_OFF, 32'h0);
        wr(IRQ_STAT_OFF, 32'h3f);
        rdc("irq clr", IRQ_STAT_OFF, 32'h0);
        fe.set_v(16'd600, 16'd1000, 16'd1000);
        settle(4);
        fe.set_v(16'd1000, 16'd1000, 16'd1000);
        rdc("irq stat", IRQ_STAT_OFF, 32'h7);
        check("irq masked", irq_s, 1'b0);
        wr(IRQ_MASK_OFF, 32'h2);
        settle(1);
        check("irq on", irq_s, 1'b1);
        wr(IRQ_STAT_OFF, 32'h2);
        settle(1);
        check("irq off", irq_s, 1'b0);
        $display("test irq done");
    endtask : t_irq

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_clamp();
        t_timing();
        t_blocks();
        t_group();
        t_irq();
        wrap_up();
    end
endmodule : uvps_bench

`default_nettype wire

// ==== verification/uvps_meas_model.sv ====
// Model of the measurement front end and the output matrix around the undervoltage block.
// Assumes its tasks are called just after a rising edge of clk.
`default_nettype none

module uvps_meas_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] trip_flag,
    output logic [15:0] v12,
    output logic [15:0] v23,
    output logic [15:0] v31,
    output logic [2:0] ext_block,
    output logic [7:0] trips_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] trip_reg;

    initial begin
        v12 = 16'h03e8;
        v23 = 16'h03e8;
        v31 = 16'h03e8;
        ext_block = 3'h0;
    end

    // The output matrix counts every rising trip it receives.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trip_reg <= 3'h0;
            trips_seen <= 8'h00;
        end else begin
            trip_reg <= trip_flag;
            trips_seen <= trips_seen + 8'($countones(trip_flag & ~trip_reg));
        end
    end

    task automatic set_v(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        v12 <= a;
        v23 <= b;
        v31 <= c;
    endtask : set_v

    task automatic set_blk(input logic [2:0] b);
        ext_block <= b;
    endtask : set_blk
endmodule : uvps_meas_model

`default_nettype wire
